// [include/acb_pkg.sv]
package acb_pkg;
   // Control byte layout
   localparam int CTRL_W = 8;
   localparam int BIT_SEL_HI = 6;
   localparam int BIT_SEL_MID = 5;
   localparam int BIT_SEL_LO = 4;
   localparam int BIT_POL = 3;
   localparam int BIT_CFG = 2;
   localparam int BIT_MODE_HI = 1;
   localparam int BIT_MODE_LO = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Operating modes carried by the two low control bits
   localparam logic [1:0] MODE_FULL_PD = 2'h0;
   localparam logic [1:0] MODE_FAST_PD = 2'h1;
   localparam logic [1:0] MODE_INT_CLK = 2'h2;
   localparam logic [1:0] MODE_EXT_CLK = 2'h3;

   // Bit counter marks and conversion lengths
   localparam int CNT_W = 4;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_FIRST = 4'h1;
   localparam logic [3:0] CNT_TRACK = 4'h5;
   localparam logic [3:0] CNT_LAST = 4'h8;
   localparam int RES_W = 10;
   localparam logic [9:0] TRIAL_MSB = 10'h200;
   localparam logic [3:0] STEP_RES_LAST = 4'h9;
   localparam logic [3:0] STEP_EXT_LAST = 4'hb;
   localparam logic [3:0] RD_COUNT = 4'ha;

   // Least acquisition time against the 40 MHz system clock
   localparam int CLK_PERIOD_PS = 25000;
   localparam int ACQ_TIME_PS = 1500000;
   localparam int ACQ_CYC_INT = (ACQ_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0] ACQ_CYCLES = ACQ_CYC_INT[7:0];
   localparam logic [7:0] ACQ_CNT_MAX = 8'hff;
endpackage

// [verilog/acb_adc_control.sv]
`timescale 1ns/1ps
// Functional notes
// - Single-ended: addressed channel goes positive, common return goes negative.
// - Differential inputs come only from pairs 0/1, 2/3, 4/5, 6/7.
// - Acquisition lasts three shift clocks, ending at falling edge after last bit.
// - Track starts at the falling edge after the fifth control bit.
// - Hold starts at the falling edge after the eighth control bit.
// - After conversion the hold capacitor returns to the positive input.
// - The conversion result is ten bits wide.
// - Byte of all ones: single-ended unipolar channel seven, external clock.
// - External mode strobe is high one period just before the result MSB.
// - Serial data and the external-mode strobe change only on falling shift clock edges.
// - First one after chip select falls is the start bit, bit 7.
// - Bits 6 to 4 select which of eight inputs convert.
// - Bit 3: one is unipolar, zero is bipolar.
// - Bit 2: one is single-ended, zero is differential.
// - Bits 1-0 pick full power-down, fast power-down, internal or external clock.
// - Single-ended select order 000,100,001,101,010,110,011,111 gives channels 0-7.
// - Differential: low bits pick pair, top bit makes the odd channel positive.
// - Zeros before the start bit are ignored.
// - Input bits are taken on rising shift clock edges.
// - Result goes MSB first, straight binary or two's complement.
module acb_adc_control (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic din_i,
   input wire logic comparator_i,
   output logic [7:0] pos_channel_sel_o,
   output logic [7:0] neg_channel_sel_o,
   output logic neg_common_sel_o,
   output logic track_o,
   output logic hold_cap_to_neg_o,
   output logic [9:0] sar_trial_o,
   output logic dout_o,
   output logic dout_oe_o,
   output logic conversion_strobe_out_o,
   output logic strobe_oe_o,
   output logic full_power_down_o,
   output logic fast_power_down_o,
   output logic polarity_select_o,
   output logic converting_o,
   output logic acquisition_short_o
);

   function automatic logic [7:0] acb_onehot(input logic [2:0] idx);
      acb_onehot = 8'h01 << idx;
   endfunction

   // Link logic is cleared whenever chip select is high, so a frame always starts clean
   wire link_rst_n = reset_n_i & ~cs_n_i;

   logic started_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic track_reg;
   logic ext_strobe_reg;
   logic ext_busy_reg;
   logic [3:0] step_reg;
   logic ext_dout_reg;
   logic [9:0] ext_trial_reg;
   logic [7:0] ctrl_reg;
   logic start_tgl_reg;
   logic done_s1_reg;
   logic done_s2_reg;
   logic done_seen_reg;
   logic [3:0] rd_cnt_reg;
   logic [9:0] rd_shift_reg;
   logic int_dout_reg;
   logic st_s1_reg;
   logic st_s2_reg;
   logic st_s3_reg;
   logic trk_s1_reg;
   logic trk_s2_reg;
   logic trk_s3_reg;
   logic [7:0] acq_cnt_reg;
   logic acq_short_reg;
   logic int_busy_reg;
   logic [3:0] int_step_reg;
   logic [9:0] int_trial_reg;
   logic [9:0] int_result_reg;
   logic done_tgl_reg;

   // Decode of the byte just completed and of the stored control byte
   wire byte_done = started_reg && (bit_cnt_reg == acb_pkg::CNT_LAST);
   wire [1:0] new_mode = shift_reg[acb_pkg::BIT_MODE_HI:acb_pkg::BIT_MODE_LO];
   wire new_ext = (new_mode == acb_pkg::MODE_EXT_CLK);
   wire new_int = (new_mode == acb_pkg::MODE_INT_CLK);
   wire [1:0] mode = ctrl_reg[acb_pkg::BIT_MODE_HI:acb_pkg::BIT_MODE_LO];
   wire int_mode = (mode == acb_pkg::MODE_INT_CLK);
   wire bipolar = ~ctrl_reg[acb_pkg::BIT_POL];
   wire single_ended = ctrl_reg[acb_pkg::BIT_CFG];
   wire sel_hi = ctrl_reg[acb_pkg::BIT_SEL_HI];
   wire sel_mid = ctrl_reg[acb_pkg::BIT_SEL_MID];
   wire sel_lo = ctrl_reg[acb_pkg::BIT_SEL_LO];
   wire [2:0] se_chan = {sel_mid, sel_lo, sel_hi};
   wire [2:0] even_chan = {sel_mid, sel_lo, 1'b0};
   wire [2:0] odd_chan = {sel_mid, sel_lo, 1'b1};
   wire [2:0] dif_pos = sel_hi ? odd_chan : even_chan;
   wire [2:0] dif_neg = sel_hi ? even_chan : odd_chan;
   wire fresh_result = done_s2_reg ^ done_seen_reg;
   wire comp_bit = comparator_i;

   // Input multiplexer steering
   assign pos_channel_sel_o = single_ended ? acb_onehot(se_chan) : acb_onehot(dif_pos);
   assign neg_channel_sel_o = single_ended ? 8'h00 : acb_onehot(dif_neg);
   assign neg_common_sel_o = single_ended;
   assign track_o = track_reg;
   // Capacitor sits on the negative side only while a conversion runs
   assign hold_cap_to_neg_o = ext_busy_reg | int_busy_reg;
   assign sar_trial_o = int_mode ? int_trial_reg : ext_trial_reg;
   assign full_power_down_o = (mode == acb_pkg::MODE_FULL_PD);
   assign fast_power_down_o = (mode == acb_pkg::MODE_FAST_PD);
   assign polarity_select_o = ctrl_reg[acb_pkg::BIT_POL];
   assign converting_o = int_busy_reg;
   assign acquisition_short_o = acq_short_reg;

   // Serial outputs; internal-mode strobe keeps driving with chip select high
   assign dout_o = int_mode ? int_dout_reg : ext_dout_reg;
   assign dout_oe_o = ~cs_n_i;
   assign conversion_strobe_out_o = int_mode ? ~int_busy_reg : ext_strobe_reg;
   assign strobe_oe_o = int_mode | ~cs_n_i;

   // Rising edge: start bit search and control byte shift-in
   always_ff @(posedge sclk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         started_reg <= 1'b0;
         bit_cnt_reg <= acb_pkg::CNT_ZERO;
         shift_reg <= 8'h00;
      end else if (!started_reg) begin
         if (din_i && !ext_busy_reg) begin
            started_reg <= 1'b1;
            bit_cnt_reg <= acb_pkg::CNT_FIRST;
            shift_reg <= 8'h01;
         end
      end else if (byte_done) begin
         started_reg <= 1'b0; // A new byte is needed for the next conversion
         bit_cnt_reg <= acb_pkg::CNT_ZERO;
      end else begin
         shift_reg <= {shift_reg[6:0], din_i};
         bit_cnt_reg <= bit_cnt_reg + acb_pkg::CNT_FIRST;
      end
   end

   // Falling edge: track/hold timing and external-clock conversion
   always_ff @(negedge sclk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         track_reg <= 1'b0;
         ext_strobe_reg <= 1'b0;
         ext_busy_reg <= 1'b0;
         step_reg <= acb_pkg::CNT_ZERO;
         ext_dout_reg <= 1'b0;
         ext_trial_reg <= acb_pkg::TRIAL_MSB;
      end else if (started_reg && bit_cnt_reg == acb_pkg::CNT_TRACK) begin
         track_reg <= 1'b1;
      end else if (byte_done) begin
         track_reg <= 1'b0;
         ext_strobe_reg <= new_ext;
         ext_busy_reg <= new_ext;
         step_reg <= acb_pkg::CNT_ZERO;
         ext_trial_reg <= acb_pkg::TRIAL_MSB;
         ext_dout_reg <= 1'b0;
      end else if (ext_busy_reg) begin
         ext_strobe_reg <= 1'b0;
         step_reg <= step_reg + acb_pkg::CNT_FIRST;
         if (step_reg <= acb_pkg::STEP_RES_LAST) begin
            // One decision per edge, MSB first; bipolar flips the MSB
            ext_dout_reg <= (step_reg == acb_pkg::CNT_ZERO) ? (comp_bit ^ bipolar) : comp_bit;
            ext_trial_reg <= (ext_trial_reg & ~(acb_pkg::TRIAL_MSB >> step_reg))
                             | ({9'h000, comp_bit} << (acb_pkg::STEP_RES_LAST - step_reg))
                             | ((acb_pkg::TRIAL_MSB >> step_reg) >> 1);
         end else begin
            ext_dout_reg <= 1'b0; // Sub-LSB padding
         end
         if (step_reg == acb_pkg::STEP_EXT_LAST) begin
            ext_busy_reg <= 1'b0;
         end
      end
   end

   // Falling edge, frame-independent: stored byte, internal start and readout
   always_ff @(negedge sclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_reg <= acb_pkg::CTRL_RESET;
         start_tgl_reg <= 1'b0;
         done_s1_reg <= 1'b0;
         done_s2_reg <= 1'b0;
         done_seen_reg <= 1'b0;
         rd_cnt_reg <= acb_pkg::CNT_ZERO;
         rd_shift_reg <= 10'h000;
         int_dout_reg <= 1'b0;
      end else begin
         done_s1_reg <= done_tgl_reg;
         done_s2_reg <= done_s1_reg;
         if (byte_done && !cs_n_i) begin
            ctrl_reg <= shift_reg;
            start_tgl_reg <= start_tgl_reg ^ new_int;
         end
         if (rd_cnt_reg != acb_pkg::CNT_ZERO) begin
            int_dout_reg <= rd_shift_reg[9];
            rd_shift_reg <= {rd_shift_reg[8:0], 1'b0};
            rd_cnt_reg <= rd_cnt_reg - acb_pkg::CNT_FIRST;
         end else if (fresh_result && !cs_n_i) begin
            done_seen_reg <= done_s2_reg;
            int_dout_reg <= int_result_reg[9]; // MSB first, held for one shift clock period
            rd_shift_reg <= {int_result_reg[8:0], 1'b0};
            rd_cnt_reg <= acb_pkg::RD_COUNT - acb_pkg::CNT_FIRST;
         end else begin
            int_dout_reg <= 1'b0;
         end
      end
   end

   // System clock: synchronisers for the start toggle and the track level
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_s1_reg <= 1'b0;
         st_s2_reg <= 1'b0;
         st_s3_reg <= 1'b0;
         trk_s1_reg <= 1'b0;
         trk_s2_reg <= 1'b0;
         trk_s3_reg <= 1'b0;
      end else begin
         st_s1_reg <= start_tgl_reg;
         st_s2_reg <= st_s1_reg;
         st_s3_reg <= st_s2_reg;
         trk_s1_reg <= track_reg;
         trk_s2_reg <= trk_s1_reg;
         trk_s3_reg <= trk_s2_reg;
      end
   end

   // Acquisition length check against the host's least time
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acq_cnt_reg <= 8'h00;
         acq_short_reg <= 1'b0;
      end else if (trk_s2_reg) begin
         if (acq_cnt_reg != acb_pkg::ACQ_CNT_MAX) begin
            acq_cnt_reg <= acq_cnt_reg + 8'h01;
         end
      end else begin
         acq_cnt_reg <= 8'h00;
         if (trk_s3_reg) begin
            acq_short_reg <= (acq_cnt_reg < acb_pkg::ACQ_CYCLES);
         end
      end
   end

   // Internal-clock conversion; bipolar bit is stable since the byte preceded the toggle
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         int_busy_reg <= 1'b0;
         int_step_reg <= acb_pkg::CNT_ZERO;
         int_trial_reg <= acb_pkg::TRIAL_MSB;
         int_result_reg <= 10'h000;
         done_tgl_reg <= 1'b0;
      end else if (st_s2_reg ^ st_s3_reg) begin
         int_busy_reg <= 1'b1;
         int_step_reg <= acb_pkg::CNT_ZERO;
         int_trial_reg <= acb_pkg::TRIAL_MSB;
      end else if (int_busy_reg) begin
         int_step_reg <= int_step_reg + acb_pkg::CNT_FIRST;
         int_trial_reg <= (int_trial_reg & ~(acb_pkg::TRIAL_MSB >> int_step_reg))
                          | ({9'h000, comp_bit} << (acb_pkg::STEP_RES_LAST - int_step_reg))
                          | ((acb_pkg::TRIAL_MSB >> int_step_reg) >> 1);
         int_result_reg <= {int_result_reg[8:0], comp_bit};
         if (int_step_reg == acb_pkg::STEP_RES_LAST) begin
            int_busy_reg <= 1'b0;
            int_result_reg <= {int_result_reg[8:0], comp_bit} ^ {bipolar, 9'h000};
            done_tgl_reg <= ~done_tgl_reg;
         end
      end
   end

   // Checks on the link side, the input multiplexer and the internal conversion
   property acq_three_p;
      @(negedge sclk_i) disable iff (!link_rst_n)
      $rose(track_reg) |-> track_reg [*3] ##1 !track_reg;
   endproperty
   sequence strobe_pulse_s;
      ext_strobe_reg ##1 !ext_strobe_reg;
   endsequence
   acq_window_a: assert property (acq_three_p) else $error("acquisition not three clocks");
   track_start_a: assert property (@(negedge sclk_i) disable iff (!link_rst_n)
      (started_reg && bit_cnt_reg == acb_pkg::CNT_TRACK) |=> track_reg)
      else $error("track did not start");
   hold_entry_a: assert property (@(negedge sclk_i) disable iff (!link_rst_n)
      byte_done |=> !track_reg && (ext_busy_reg == $past(new_ext)))
      else $error("hold not entered");
   strobe_one_a: assert property (@(negedge sclk_i) disable iff (!link_rst_n)
      (byte_done && new_ext) |=> strobe_pulse_s)
      else $error("strobe not one period");
   ext_length_a: assert property (@(negedge sclk_i) disable iff (!link_rst_n)
      (ext_busy_reg && step_reg == acb_pkg::STEP_EXT_LAST) |=> !ext_busy_reg)
      else $error("external conversion length wrong");
   start_bit_a: assert property (@(posedge sclk_i) disable iff (!link_rst_n)
      (!started_reg && din_i && !ext_busy_reg) |=> started_reg && shift_reg == 8'h01)
      else $error("start bit not taken");
   zero_skip_a: assert property (@(posedge sclk_i) disable iff (!link_rst_n)
      (!started_reg && !din_i) |=> !started_reg && bit_cnt_reg == acb_pkg::CNT_ZERO)
      else $error("leading zero counted");
   se_route_a: assert property (@(negedge sclk_i) disable iff (!reset_n_i)
      single_ended |-> neg_common_sel_o && neg_channel_sel_o == 8'h00
         && pos_channel_sel_o == acb_onehot(se_chan))
      else $error("single-ended routing wrong");
   dif_pair_a: assert property (@(negedge sclk_i) disable iff (!reset_n_i)
      !single_ended |-> (pos_channel_sel_o | neg_channel_sel_o) == (8'h03 << {sel_mid, sel_lo, 1'b0}))
      else $error("differential pair wrong");
   int_steps_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $rose(int_busy_reg) |-> ##10 !int_busy_reg)
      else $error("internal conversion not ten steps");

endmodule

// [tb/acb_host_model.sv]
`timescale 1ns/1ps
module acb_host_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic din_o,
   input wire logic dout_i,
   input wire logic track_i,
   input wire logic strobe_i,
   input wire logic hold_i
);
   // Per rising edge: {hold, strobe, track, dout} as launched by the previous falling edge
   logic [3:0] rec [64];
   int n_rise;
   realtime half_ns = 7.5;

   // Serial clock stands still low between frames
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o = 1'b0;
      n_rise = 0;
   end

   // Sampling at the rising edge keeps us clear of the falling-edge updates
   always @(posedge sclk_o) begin
      if (n_rise < 64) rec[n_rise] = {hold_i, strobe_i, track_i, dout_i};
      n_rise = n_rise + 1;
   end

   // Frame: leading zeros, top nb bits of the byte, then padding clocks with input low
   task automatic frame(input int z, input logic [7:0] c, input int nb, input int pad);
      int i;
      n_rise = 0;
      cs_n_o = 1'b0;
      for (i = 0; i < z + nb + pad; i++) begin
         din_o = (i >= z && i < z + nb) ? c[7 - (i - z)] : 1'b0;
         #(half_ns) sclk_o = 1'b1;
         #(half_ns) sclk_o = 1'b0;
      end
      #(half_ns) cs_n_o = 1'b1;
      din_o = ~din_o; // Deselected line must not look like a held bit
      // Chip select stays high a full period so back-to-back frames really clear the link
      #(2.0 * half_ns);
   endtask
endmodule

// [tb/adc_control_byte_input_select_test.sv]
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("mismatch at %0t: %s", $time, m); end end
module adc_control_byte_input_select_test;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic comparator_i = 1'b1;
   wire sclk, cs_n, din, dout, dout_oe, strobe, strobe_oe, track, hold;
   wire neg_common, full_pd, fast_pd, pol, converting, acq_short;
   wire [7:0] pos_sel, neg_sel;
   wire [9:0] trial;
   int n_mismatch = 0;
   int n_tests = 0;
   int k;

   // System clock at 40 MHz
   always #12.5 clk_i = ~clk_i;

   acb_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout),
      .track_i(track), .strobe_i(strobe), .hold_i(hold));

   acb_adc_control DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .din_i(din), .comparator_i(comparator_i), .pos_channel_sel_o(pos_sel),
      .neg_channel_sel_o(neg_sel), .neg_common_sel_o(neg_common), .track_o(track),
      .hold_cap_to_neg_o(hold), .sar_trial_o(trial), .dout_o(dout), .dout_oe_o(dout_oe),
      .conversion_strobe_out_o(strobe), .strobe_oe_o(strobe_oe),
      .full_power_down_o(full_pd), .fast_power_down_o(fast_pd),
      .polarity_select_o(pol), .converting_o(converting), .acquisition_short_o(acq_short));

   // Expected {common, negative, positive}; both configurations index by bits 5,4,6
   function automatic logic [16:0] exp_mux(input logic [7:0] c);
      logic [2:0] ch;
      ch = {c[5], c[4], c[6]};
      if (c[2]) return {1'b1, 8'h00, 8'h01 << ch};
      return {1'b0, 8'h01 << {c[5], c[4], ~c[6]}, 8'h01 << ch};
   endfunction

   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic t_reset;
      `CHK({neg_common, neg_sel, pos_sel}, exp_mux(8'h00), "reset mux")
      `CHK({full_pd, fast_pd, pol}, 3'b100, "reset mode")
   endtask

   // External clock conversion with comparator high: full-scale code
   task automatic t_ext(input logic [7:0] c, input int z);
      int i;
      host.frame(z, c, 8, 16);
      `CHK({neg_common, neg_sel, pos_sel}, exp_mux(c), "mux")
      `CHK({pol, full_pd, fast_pd}, {c[3], 2'b00}, "polarity")
      for (i = 5; i <= 8; i++) `CHK(host.rec[z+i][1], i < 8, "track")
      `CHK(host.rec[z+8][2:1], 2'b10, "strobe on")
      `CHK(host.rec[z+9][2], 1'b0, "strobe off")
      `CHK(host.rec[z+9][3], 1'b1, "hold")
      for (i = 0; i < 10; i++) `CHK(host.rec[z+9+i][0], (i == 0) ? c[3] : 1'b1, "data")
      `CHK(host.rec[z+22][3], 1'b0, "reconnect")
      `CHK({dout_oe, strobe_oe, trial}, {2'b00, acb_pkg::TRIAL_MSB}, "released")
   endtask

   // An aborted byte must leave no bits behind
   task automatic t_abort;
      host.frame(0, 8'hb0, 4, 0);
      t_ext(8'h8f, 0);
   endtask

   task automatic t_modes;
      for (k = 0; k < 2; k++) begin
         host.frame(0, 8'h8c | k[1:0], 8, 16);
         `CHK({full_pd, fast_pd}, {k == 0, k == 1}, "power mode")
      end
   endtask

   // Internal clock, bipolar, comparator low: only the inverted MSB is a one
   task automatic t_int;
      int i;
      logic [4:0] ones;
      @(negedge clk_i) comparator_i = 1'b0;
      host.frame(0, 8'h86, 8, 0);
      for (i = 0; i < 100 && converting !== 1'b1; i++) @(negedge clk_i);
      `CHK({converting, strobe, hold}, 3'b101, "int busy")
      for (i = 0; i < 100 && converting !== 1'b0; i++) @(negedge clk_i);
      `CHK({converting, strobe, hold}, 3'b010, "int done")
      `CHK({trial, dout_oe, strobe_oe}, {10'h000, 2'b01}, "int trial")
      host.frame(0, 8'h00, 0, 16);
      ones = 5'h00;
      for (i = 0; i < 16; i++) ones = ones + host.rec[i][0];
      `CHK(ones, 5'h01, "int data")
      @(negedge clk_i) comparator_i = 1'b1;
   endtask

   // Short acquisition at the fast link clock, long one when slowed
   task automatic t_acq;
      `CHK(acq_short, 1'b1, "acq short")
      host.half_ns = 400.0;
      host.frame(0, 8'h8f, 8, 16);
      host.half_ns = 7.5;
      repeat (4) @(negedge clk_i);
      `CHK(acq_short, 1'b0, "acq long")
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      @(negedge clk_i) reset_n_i = 1'b1;
      repeat (2) @(negedge clk_i);
      t_reset();
      for (k = 0; k < 16; k++) t_ext({1'b1, k[2:0], k[0], k[3], 2'b11}, k % 3);
      t_abort();
      t_modes();
      t_int();
      t_acq();
      stop_test();
   end

   // Watchdog well beyond the expected run of some 30 us
   initial begin
      #500us;
      n_mismatch++;
      $display("mismatch at %0t: watchdog", $time);
      stop_test();
   end
endmodule
